// ===== hw/cit_cfg.svh
// named constants for the instruction timing and memory map unit
// assumes inclusion by bare name from the unit; the package does not include it
`ifndef CIT_CFG_SVH
`define CIT_CFG_SVH
// instruction lengths in bytes
`define CIT_LEN_1 2'd1
`define CIT_LEN_2 2'd2
`define CIT_LEN_3 2'd3
// base clock cycle counts
`define CIT_CYC_1 3'd1
`define CIT_CYC_2 3'd2
`define CIT_CYC_3 3'd3
`define CIT_CYC_4 3'd4
`define CIT_CYC_5 3'd5
// opcodes with fixed encodings
`define CIT_OP_NOP      8'h00
`define CIT_OP_NOP_ALT  8'ha5
`define CIT_OP_CODE_BYTE_MOVE_PC  8'h83
`define CIT_OP_CODE_BYTE_MOVE_DP  8'h93
`define CIT_OP_XRD_DP   8'he0
`define CIT_OP_XWR_DP   8'hf0
`define CIT_OP_PUSH     8'hc0
`define CIT_OP_POP      8'hd0
`define CIT_OP_XCH_DIR  8'hc5
`define CIT_OP_LONG_CALL    8'h12
`define CIT_OP_LONG_JUMP     8'h02
`define CIT_OP_RET      8'h22
`define CIT_OP_INTERRUPT_RETURN     8'h32
`define CIT_OP_SHORT_JUMP     8'h80
`define CIT_OP_JMP_DP   8'h73
`define CIT_OP_JBC      8'h10
`define CIT_OP_DECREMENT_JUMP_DIR 8'hd5
// memory map
`define CIT_RAM_LOW_TOP 8'h7f
`define CIT_BIT_BASE    8'h20
`define CIT_BIT_LOW_TOP 8'h7f
`define CIT_FLASH_FULL  8192
`define CIT_FLASH_RSVD  17'h1e00
`define CIT_REL_SIGN    7
`endif

// ===== hw/cit_core.sv
// instruction length, timing, branch resolution and memory map decode
// assumes operands and condition values are presented with start_i
`timescale 1ns/1ps
`default_nettype none
`include "cit_cfg.svh"

module cit_core
    import cit_pkg::*;
#(
    parameter int FLASH_SIZE = `CIT_FLASH_FULL
) (
    input  wire  logic        sys_clk_i,
    input  wire  logic        reset_n_i,
    input  wire  logic        start_i,
    input  wire  logic [7:0]  opcode_i,
    input  wire  logic [7:0]  op1_i,
    input  wire  logic [7:0]  op2_i,
    input  wire  logic [15:0] pc_next_i,
    input  wire  logic [15:0] ret_addr_i,
    input  wire  logic [15:0] data_pointer_i,
    input  wire  logic [7:0]  acc_i,
    input  wire  logic        carry_i,
    input  wire  logic        bit_val_i,
    input  wire  logic [7:0]  cmp_left_i,
    input  wire  logic [7:0]  cmp_right_i,
    input  wire  logic [7:0]  dec_val_i,
    input  wire  logic [7:0]  ind_mem_i,
    input  wire  logic [7:0]  ri_val_i,
    input  wire  logic [1:0]  bank_sel_i,
    input  wire  logic        store_wr_en_i,
    input  wire  logic [7:0]  daddr_i,
    input  wire  logic        dindirect_i,
    input  wire  logic [7:0]  bitaddr_i,
    input  wire  logic [15:0] paddr_i,
    output logic              ready_o,
    output logic              known_o,
    output logic [1:0]        len_o,
    output logic [2:0]        cycles_o,
    output logic              jump_o,
    output logic [15:0]       target_o,
    output logic              long_ok_o,
    output logic              clr_bit_o,
    output logic [7:0]        dec_result_o,
    output logic [7:0]        nib_acc_o,
    output logic [7:0]        nib_mem_o,
    output logic [4:0]        bank_reg_addr_o,
    output logic              flash_rd_o,
    output logic              flash_wr_o,
    output logic [15:0]       flash_addr_o,
    output logic [7:0]        flash_data_o,
    output logic              ram_low_sel_o,
    output logic              ram_up_sel_o,
    output logic              sfr_sel_o,
    output logic [7:0]        bit_byte_o,
    output logic [2:0]        bit_idx_o,
    output logic              pmem_hit_o,
    output logic              pmem_user_o
);
    logic [1:0]  len_d;
    logic [2:0]  cyc_d;
    logic        known_d;
    cit_cond_e   cond_d;
    cit_tgt_e    tgt_d;
    logic        xrd_d;
    logic        xwr_d;
    logic        nibble_exchange_d;
    logic        taken_d;
    logic [2:0]  total_d;
    logic [15:0] target_d;
    logic [7:0]  rel_d;
    logic [7:0]  dec_d;
    logic [15:0] xaddr_d;
    logic        issue;
    logic [2:0]  cnt_q;
    logic [2:0]  cnt_d;
    cit_state_e  state_q;
    logic [1:0]  len_q;
    logic [2:0]  cyc_q;
    logic        known_q;
    logic        jump_q;
    logic [15:0] target_q;
    logic        clr_bit_q;
    logic [7:0]  dec_q;
    logic [7:0]  nib_acc_q;
    logic [7:0]  nib_mem_q;
    logic [4:0]  bank_q;
    logic        flash_rd_q;
    logic        flash_wr_q;
    logic [15:0] flash_addr_q;
    logic [7:0]  flash_data_q;
    logic [16:0] flash_lim;
    logic [16:0] user_lim;

    assign flash_lim = 17'(FLASH_SIZE);
    // factory area withheld on the largest variant only
    assign user_lim  = (FLASH_SIZE == `CIT_FLASH_FULL) ? `CIT_FLASH_RSVD : flash_lim;

    // opcode to length, cycles, condition and target kind
    always_comb begin
        len_d   = `CIT_LEN_1;
        cyc_d   = `CIT_CYC_1;
        known_d = 1'b1;
        cond_d  = cond_none;
        tgt_d   = tgt_none;
        xrd_d   = 1'b0;
        xwr_d   = 1'b0;
        nibble_exchange_d  = 1'b0;
        casez (opcode_i)
            `CIT_OP_NOP, `CIT_OP_NOP_ALT: begin
            end
            `CIT_OP_CODE_BYTE_MOVE_PC, `CIT_OP_CODE_BYTE_MOVE_DP: cyc_d = `CIT_CYC_3;
            `CIT_OP_XRD_DP, 8'he2, 8'he3: begin
                cyc_d = `CIT_CYC_3;
                xrd_d = 1'b1;
            end
            `CIT_OP_XWR_DP, 8'hf2, 8'hf3: begin
                cyc_d = `CIT_CYC_3;
                xwr_d = 1'b1;
            end
            `CIT_OP_PUSH, `CIT_OP_POP: begin
                len_d = `CIT_LEN_2;
                cyc_d = `CIT_CYC_2;
            end
            8'b1100_1???: cyc_d = `CIT_CYC_1;
            `CIT_OP_XCH_DIR: begin
                len_d = `CIT_LEN_2;
                cyc_d = `CIT_CYC_2;
            end
            8'b1100_011?: cyc_d = `CIT_CYC_2;
            8'b1101_011?: begin
                cyc_d  = `CIT_CYC_2;
                nibble_exchange_d = 1'b1;
            end
            8'hc3, 8'hd3, 8'hb3: cyc_d = `CIT_CYC_1;
            8'hc2, 8'hd2, 8'hb2, 8'h82, 8'hb0, 8'h72, 8'ha0, 8'ha2, 8'h92: begin
                len_d = `CIT_LEN_2;
                cyc_d = `CIT_CYC_2;
            end
            8'h40, 8'h50, 8'h60, 8'h70: begin
                len_d  = `CIT_LEN_2;
                cyc_d  = `CIT_CYC_2;
                tgt_d  = tgt_rel1;
                cond_d = (opcode_i == 8'h40) ? cond_carry :
                         (opcode_i == 8'h50) ? cond_ncarry :
                         (opcode_i == 8'h60) ? cond_zero : cond_nzero;
            end
            8'h20, 8'h30, `CIT_OP_JBC: begin
                len_d  = `CIT_LEN_3;
                cyc_d  = `CIT_CYC_3;
                tgt_d  = tgt_rel2;
                cond_d = (opcode_i == 8'h20) ? cond_bit :
                         (opcode_i == 8'h30) ? cond_nbit : cond_bitclr;
            end
            8'b???1_0001: begin
                len_d = `CIT_LEN_2;
                cyc_d = `CIT_CYC_3;
                tgt_d = tgt_abs;
            end
            8'b???0_0001: begin
                len_d = `CIT_LEN_2;
                cyc_d = `CIT_CYC_3;
                tgt_d = tgt_abs;
            end
            `CIT_OP_LONG_CALL, `CIT_OP_LONG_JUMP: begin
                len_d = `CIT_LEN_3;
                cyc_d = `CIT_CYC_4;
                tgt_d = tgt_long;
            end
            `CIT_OP_RET, `CIT_OP_INTERRUPT_RETURN: begin
                cyc_d = `CIT_CYC_5;
                tgt_d = tgt_ret;
            end
            `CIT_OP_SHORT_JUMP: begin
                len_d = `CIT_LEN_2;
                cyc_d = `CIT_CYC_3;
                tgt_d = tgt_rel1;
            end
            `CIT_OP_JMP_DP: begin
                cyc_d = `CIT_CYC_3;
                tgt_d = tgt_data_pointer;
            end
            8'hb4, 8'hb5, 8'b1011_1???: begin
                len_d  = `CIT_LEN_3;
                cyc_d  = `CIT_CYC_3;
                tgt_d  = tgt_rel2;
                cond_d = cond_cmp;
            end
            8'b1011_011?: begin
                len_d  = `CIT_LEN_3;
                cyc_d  = `CIT_CYC_4;
                tgt_d  = tgt_rel2;
                cond_d = cond_cmp;
            end
            8'b1101_1???: begin
                len_d  = `CIT_LEN_2;
                cyc_d  = `CIT_CYC_2;
                tgt_d  = tgt_rel1;
                cond_d = cond_decrement_jump;
            end
            `CIT_OP_DECREMENT_JUMP_DIR: begin
                len_d  = `CIT_LEN_3;
                cyc_d  = `CIT_CYC_3;
                tgt_d  = tgt_rel2;
                cond_d = cond_decrement_jump;
            end
            default: known_d = 1'b0;
        endcase
    end

    assign dec_d = dec_val_i - 8'h01;

    // branch outcome
    always_comb begin
        case (cond_d)
            cond_none:   taken_d = (tgt_d != tgt_none);
            cond_carry:  taken_d = carry_i;
            cond_ncarry: taken_d = !carry_i;
            cond_zero:   taken_d = (acc_i == 8'h00);
            cond_nzero:  taken_d = (acc_i != 8'h00);
            cond_bit:    taken_d = bit_val_i;
            cond_nbit:   taken_d = !bit_val_i;
            cond_bitclr: taken_d = bit_val_i;
            cond_cmp:    taken_d = (cmp_left_i != cmp_right_i);
            cond_decrement_jump:   taken_d = (dec_d != 8'h00);
            default:     taken_d = 1'b0;
        endcase
    end

    // a taken conditional branch costs one extra cycle
    assign total_d = (cond_d != cond_none && taken_d) ? cyc_d + `CIT_CYC_1 : cyc_d;

    assign rel_d = (tgt_d == tgt_rel2) ? op2_i : op1_i;

    always_comb begin
        case (tgt_d)
            tgt_rel1, tgt_rel2:
                target_d = pc_next_i + {{8{rel_d[`CIT_REL_SIGN]}}, rel_d};
            // stay within the current 2K page
            tgt_abs:  target_d = {pc_next_i[15:11], opcode_i[7:5], op1_i};
            tgt_long: target_d = {op1_i, op2_i};
            tgt_data_pointer: target_d = data_pointer_i + {8'h00, acc_i};
            tgt_ret:  target_d = ret_addr_i;
            default:  target_d = pc_next_i;
        endcase
    end

    // external data addresses go to program flash
    assign xaddr_d = opcode_i[1] ? {8'h00, ri_val_i} : data_pointer_i;

    // issue only once the previous instruction has run out
    assign ready_o = (state_q == st_idle);
    assign issue   = start_i && ready_o;
    assign cnt_d   = issue ? total_d - 3'd1 : (ready_o ? cnt_q : cnt_q - 3'd1);

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_q <= 3'd0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q <= st_idle;
        end else begin
            case (cnt_d)
                3'd0:    state_q <= st_idle;
                3'd1:    state_q <= st_last;
                default: state_q <= st_run;
            endcase
        end
    end

    // decode results held for the instruction's lifetime
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            len_q    <= `CIT_LEN_1;
            cyc_q    <= `CIT_CYC_1;
            known_q  <= 1'b1;
            target_q <= 16'h0000;
            dec_q    <= 8'h00;
            bank_q   <= 5'h00;
        end else if (issue) begin
            len_q    <= len_d;
            cyc_q    <= total_d;
            known_q  <= known_d;
            target_q <= target_d;
            dec_q    <= dec_d;
            // bank register address from bank select and index
            bank_q   <= {bank_sel_i, opcode_i[2:0]};
        end
    end

    // one-cycle effect pulses
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            jump_q     <= 1'b0;
            clr_bit_q  <= 1'b0;
            flash_rd_q <= 1'b0;
            flash_wr_q <= 1'b0;
        end else begin
            jump_q     <= issue && taken_d;
            // clear the tested bit when the jump occurs
            clr_bit_q  <= issue && cond_d == cond_bitclr && taken_d;
            flash_rd_q <= issue && xrd_d;
            // stores only while the store enable is set
            flash_wr_q <= issue && xwr_d && store_wr_en_i
                          && ({1'b0, xaddr_d} < user_lim);
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            flash_addr_q <= 16'h0000;
            flash_data_q <= 8'h00;
            nib_acc_q    <= 8'h00;
            nib_mem_q    <= 8'h00;
        end else if (issue) begin
            flash_addr_q <= xaddr_d;
            flash_data_q <= acc_i;
            if (nibble_exchange_d) begin
                // low nibbles swap, high nibbles stay
                nib_acc_q <= {acc_i[7:4], ind_mem_i[3:0]};
                nib_mem_q <= {ind_mem_i[7:4], acc_i[3:0]};
            end
        end
    end

    assign len_o           = len_q;
    assign cycles_o        = cyc_q;
    assign known_o         = known_q;
    assign jump_o          = jump_q;
    assign target_o        = target_q;
    assign long_ok_o       = ({1'b0, target_q} < flash_lim);
    assign clr_bit_o       = clr_bit_q;
    assign dec_result_o    = dec_q;
    assign nib_acc_o       = nib_acc_q;
    assign nib_mem_o       = nib_mem_q;
    assign bank_reg_addr_o = bank_q;
    assign flash_rd_o      = flash_rd_q;
    assign flash_wr_o      = flash_wr_q;
    assign flash_addr_o    = flash_addr_q;
    assign flash_data_o    = flash_data_q;

    assign ram_low_sel_o = (daddr_i <= `CIT_RAM_LOW_TOP);
    // mode picks upper ram or function registers
    assign ram_up_sel_o  = !ram_low_sel_o && dindirect_i;
    assign sfr_sel_o     = !ram_low_sel_o && !dindirect_i;

    // bit addresses below 80 land in bytes 20-2f
    assign bit_byte_o = (bitaddr_i <= `CIT_BIT_LOW_TOP)
                        ? `CIT_BIT_BASE + {4'h0, bitaddr_i[6:3]}
                        : {bitaddr_i[7:3], 3'b000};
    assign bit_idx_o  = bitaddr_i[2:0];

    assign pmem_hit_o  = ({1'b0, paddr_i} < flash_lim);
    assign pmem_user_o = ({1'b0, paddr_i} < user_lim);

    // checks
    code_byte_move_time_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        issue && opcode_i == `CIT_OP_CODE_BYTE_MOVE_PC |=> cycles_o == 3'd3 && len_o == 2'd1
            ##1 !ready_o ##1 ready_o)
        else $error("code byte move timing wrong");
    xdata_time_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        issue && (xrd_d || xwr_d) |=> cycles_o == 3'd3 && !ready_o)
        else $error("external move timing wrong");
    push_pop_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        issue && (opcode_i == `CIT_OP_PUSH || opcode_i == `CIT_OP_POP)
            |=> len_o == 2'd2 && cycles_o == 3'd2)
        else $error("push or pop timing wrong");
    nibble_swap_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        issue && nibble_exchange_d |=> nib_mem_o == {$past(ind_mem_i[7:4]), $past(acc_i[3:0])})
        else $error("nibble exchange wrong");
    cond_extra_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        issue && cond_d != cond_none |=> cycles_o == $past(cyc_d) + {2'b00, jump_o})
        else $error("taken branch cycle count wrong");
    bit_clear_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        clr_bit_o |-> jump_o && $past(opcode_i) == `CIT_OP_JBC && $past(bit_val_i))
        else $error("bit cleared without a taken test");
    ret_time_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        issue && tgt_d == tgt_ret |=> !ready_o [*4] ##1 ready_o)
        else $error("return timing wrong");
    page_keep_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        issue && tgt_d == tgt_abs |=> target_o[15:11] == $past(pc_next_i[15:11]))
        else $error("absolute target left its page");
    nop_alt_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        issue && opcode_i == `CIT_OP_NOP_ALT |=> ready_o && cycles_o == 3'd1 && !jump_o)
        else $error("alternate no-op misbehaves");
    store_gate_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        flash_wr_o |-> $past(store_wr_en_i) && $past(xwr_d))
        else $error("flash write without enable");
    space_pick_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        daddr_i > `CIT_RAM_LOW_TOP |-> ram_up_sel_o == dindirect_i && sfr_sel_o != dindirect_i)
        else $error("upper space selection wrong");
    taken_jump_c: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        issue && cond_d == cond_cmp && taken_d ##1 jump_o);
    flash_store_c: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i) flash_wr_o);
    back_to_back_c: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        issue ##1 issue ##1 issue);
endmodule // cit_core
`default_nettype wire

// ===== hw/cit_pkg.sv
// types for the instruction timing and memory map unit
// assumes cit_cfg.svh is on the include path
package cit_pkg;
    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_run  = 2'b01,
        st_last = 2'b11
    } cit_state_e;

    typedef enum logic [3:0] {
        cond_none, cond_carry, cond_ncarry, cond_zero, cond_nzero,
        cond_bit, cond_nbit, cond_bitclr, cond_cmp, cond_decrement_jump
    } cit_cond_e;

    typedef enum logic [2:0] {
        tgt_none, tgt_rel1, tgt_rel2, tgt_abs, tgt_long, tgt_data_pointer, tgt_ret
    } cit_tgt_e;
endpackage

// ===== verif/cit_core_test.sv
// bench for the instruction timing and memory map unit
// assumes cit_flash_model on the write port, 25 MHz clock
`timescale 1ns/1ps
`default_nettype none
module cit_core_test;
    logic        sys_clk_i = 1'b0, reset_n_i = 1'b0, start_i = 1'b0, carry_i = 1'b0;
    logic        bit_val_i = 1'b0, store_wr_en_i = 1'b0, dindirect_i = 1'b0;
    logic [7:0]  opcode_i = 8'h00, op1_i = 8'h00, op2_i = 8'h00, acc_i = 8'h00;
    logic [7:0]  cmp_left_i = 8'h00, cmp_right_i = 8'h00, dec_val_i = 8'h00;
    logic [7:0]  ind_mem_i = 8'h00, ri_val_i = 8'h00, daddr_i = 8'h00, bitaddr_i = 8'h00;
    logic [15:0] pc_next_i = 16'h0000, ret_addr_i = 16'h0000, data_pointer_i = 16'h0000;
    logic [15:0] paddr_i = 16'h0000, target_o, flash_addr_o;
    logic [1:0]  bank_sel_i = 2'h0, len_o;
    logic        ready_o, known_o, jump_o, long_ok_o, clr_bit_o, flash_rd_o, flash_wr_o;
    logic        ram_low_sel_o, ram_up_sel_o, sfr_sel_o, pmem_hit_o, pmem_user_o;
    logic [2:0]  cycles_o, bit_idx_o;
    logic [7:0]  dec_result_o, nib_acc_o, nib_mem_o, flash_data_o, bit_byte_o, stored;
    logic [4:0]  bank_reg_addr_o;
    logic [3:0]  pls;
    int          failures = 0, n_compared = 0, cyc = 0, n;
    // opcode, then length and cycles in nibbles
    localparam logic [15:0] FIXED [26] = '{16'hc022, 16'hd022, 16'hc811, 16'hc522, 16'hc712,
        16'hc311, 16'hd311, 16'hb311, 16'hc222, 16'hd222, 16'hb222, 16'h8222, 16'hb022,
        16'h7222, 16'ha022, 16'ha222, 16'h9222, 16'h0011, 16'ha511, 16'h8313, 16'h9313,
        16'he213, 16'he313, 16'hf213, 16'hd612, 16'hcd11};

    cit_core u_dut (
        .sys_clk_i, .reset_n_i, .start_i, .opcode_i, .op1_i, .op2_i, .pc_next_i,
        .ret_addr_i, .data_pointer_i, .acc_i, .carry_i, .bit_val_i, .cmp_left_i, .cmp_right_i,
        .dec_val_i, .ind_mem_i, .ri_val_i, .bank_sel_i, .store_wr_en_i, .daddr_i,
        .dindirect_i, .bitaddr_i, .paddr_i, .ready_o, .known_o, .len_o, .cycles_o,
        .jump_o, .target_o, .long_ok_o, .clr_bit_o, .dec_result_o, .nib_acc_o,
        .nib_mem_o, .bank_reg_addr_o, .flash_rd_o, .flash_wr_o, .flash_addr_o,
        .flash_data_o, .ram_low_sel_o, .ram_up_sel_o, .sfr_sel_o, .bit_byte_o,
        .bit_idx_o, .pmem_hit_o, .pmem_user_o
    );
    cit_flash_model u_flash (.sys_clk_i, .wr_i(flash_wr_o), .addr_i(flash_addr_o),
        .data_i(flash_data_o), .stored_o(stored));

    always #20 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            failures++;
            stop_test();
        end
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // issue, then count edges until the next issue is allowed
    task automatic iss(input logic [7:0] op, input logic [7:0] lc, input logic j);
        @(posedge sys_clk_i);
        opcode_i <= op;
        start_i <= 1'b1;
        @(posedge sys_clk_i);
        start_i <= 1'b0;
        #1;
        pls = {jump_o, clr_bit_o, flash_rd_o, flash_wr_o};
        n = 1;
        while (ready_o !== 1'b1 && n < 8) begin
            @(posedge sys_clk_i);
            #1;
            n++;
        end
        chk("length", {14'h0, lc[5:4]}, {14'h0, len_o});
        chk("cycles", {13'h0, lc[2:0]}, {13'h0, cycles_o});
        chk("spacing", {13'h0, lc[2:0]}, 16'(n));
        chk("jump", {15'h0, j}, {15'h0, pls[3]});
    endtask

    task automatic t_fixed();
        acc_i <= 8'hab;
        ind_mem_i <= 8'hcd;
        bank_sel_i <= 2'h2;
        foreach (FIXED[i]) iss(FIXED[i][15:8], FIXED[i][7:0], 1'b0);
        chk("nibble acc", 16'h00ad, nib_acc_o);
        chk("nibble mem", 16'h00cb, nib_mem_o);
        chk("bank reg", 16'h0015, bank_reg_addr_o);
        iss(8'ha5, 8'h11, 1'b0);
        chk("alt nop known", 16'h1, known_o);
    endtask

    task automatic t_store();
        data_pointer_i <= 16'h0123;
        ri_val_i <= 8'h5a;
        acc_i <= 8'h3c;
        iss(8'he2, 8'h13, 1'b0);
        chk("read pulse", 16'h1, pls[1]);
        chk("byte addr", 16'h005a, flash_addr_o);
        iss(8'hf0, 8'h13, 1'b0);
        chk("locked write", 16'h0, pls[0]);
        store_wr_en_i <= 1'b1;
        iss(8'hf0, 8'h13, 1'b0);
        chk("write pulse", 16'h1, pls[0]);
        chk("stored", 16'h003c, stored);
        data_pointer_i <= 16'h1e00;
        iss(8'hf0, 8'h13, 1'b0);
        chk("reserved write", 16'h0, pls[0]);
        store_wr_en_i <= 1'b0;
    endtask

    task automatic t_branch();
        pc_next_i <= 16'h1802;
        op1_i <= 8'h34;
        op2_i <= 8'h56;
        ret_addr_i <= 16'h0abc;
        data_pointer_i <= 16'h0123;
        acc_i <= 8'h10;
        iss(8'he1, 8'h23, 1'b1);
        chk("page target", 16'h1f34, target_o);
        iss(8'h11, 8'h23, 1'b1);
        chk("page target", 16'h1834, target_o);
        iss(8'h12, 8'h34, 1'b1);
        chk("far target", 16'h3456, target_o);
        chk("far ok", 16'h0, long_ok_o);
        iss(8'h22, 8'h15, 1'b1);
        chk("return target", 16'h0abc, target_o);
        iss(8'h32, 8'h15, 1'b1);
        iss(8'h73, 8'h13, 1'b1);
        chk("pointer target", 16'h0133, target_o);
        op1_i <= 8'h80;
        iss(8'h80, 8'h23, 1'b1);
        chk("rel target", 16'h1782, target_o);
        op1_i <= 8'h1f;
        iss(8'h02, 8'h34, 1'b1);
        chk("near ok", 16'h1, long_ok_o);
    endtask

    task automatic t_cond();
        carry_i <= 1'b1;
        iss(8'h40, 8'h23, 1'b1);
        iss(8'h50, 8'h22, 1'b0);
        acc_i <= 8'h00;
        iss(8'h60, 8'h23, 1'b1);
        iss(8'h70, 8'h22, 1'b0);
        bit_val_i <= 1'b1;
        iss(8'h30, 8'h33, 1'b0);
        iss(8'h10, 8'h34, 1'b1);
        chk("bit clear", 16'h1, pls[2]);
        bit_val_i <= 1'b0;
        iss(8'h10, 8'h33, 1'b0);
        chk("bit kept", 16'h0, pls[2]);
        cmp_left_i <= 8'h05;
        cmp_right_i <= 8'h06;
        iss(8'hb6, 8'h35, 1'b1);
        cmp_right_i <= 8'h05;
        iss(8'hbb, 8'h33, 1'b0);
        dec_val_i <= 8'h01;
        iss(8'hd9, 8'h22, 1'b0);
        chk("dec result", 16'h0, dec_result_o);
        dec_val_i <= 8'h00;
        iss(8'hd5, 8'h34, 1'b1);
    endtask

    task automatic t_decode();
        daddr_i <= 8'h85;
        bitaddr_i <= 8'h13;
        paddr_i <= 16'h1e00;
        #1;
        chk("sfr", 16'h1, sfr_sel_o);
        chk("bit byte", 16'h0022, bit_byte_o);
        chk("bit index", 16'h0003, bit_idx_o);
        chk("user area", 16'h0, pmem_user_o);
        chk("flash hit", 16'h1, pmem_hit_o);
        dindirect_i <= 1'b1;
        paddr_i <= 16'h2000;
        #1;
        chk("upper ram", 16'h1, ram_up_sel_o);
        chk("flash miss", 16'h0, pmem_hit_o);
        daddr_i <= 8'h10;
        #1;
        chk("low ram", 16'h1, ram_low_sel_o);
    endtask

    task automatic stop_test();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        t_fixed();
        t_store();
        t_branch();
        t_cond();
        t_decode();
        stop_test();
    end
endmodule // cit_core_test
`default_nettype wire

// ===== verif/cit_flash_model.sv
// flash model on the external data move write port
// assumes one clock and single cycle write pulses
`timescale 1ns/1ps
`default_nettype none
module cit_flash_model (
    input  wire logic        sys_clk_i,
    input  wire logic        wr_i,
    input  wire logic [15:0] addr_i,
    input  wire logic [7:0]  data_i,
    output logic [7:0]       stored_o
);
    logic [7:0] mem_q [8192];
    // erased flash reads all ones
    initial foreach (mem_q[i]) mem_q[i] = 8'hff;
    always @(posedge sys_clk_i) if (wr_i) mem_q[addr_i[12:0]] <= data_i;
    assign stored_o = (addr_i[15:13] == 3'h0) ? mem_q[addr_i[12:0]] : ~data_i;
endmodule // cit_flash_model
`default_nettype wire
